/* src/srw_pkg.sv */
// Shared constants and types for the supervisor reset and watchdog core.
package srw_pkg;

  // ---------------------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------------------
  localparam real CLK_MHZ = 100.0;

  // Reset timeout; the figure is a neutral default, the part is factory trimmed.
  localparam real         RST_TIMEOUT_US = 200.0;
  localparam int unsigned RST_CYC_DEF    = $rtoi($ceil(RST_TIMEOUT_US * CLK_MHZ));

  // Manual reset: least qualifying low width, then nominal assertion delay.
  localparam real         MR_PULSE_US  = 25.0;
  localparam real         MR_DELAY_US  = 12.0;
  localparam int unsigned MR_QUAL_CYC  = $rtoi($ceil(MR_PULSE_US * CLK_MHZ));
  localparam int unsigned MR_DELAY_CYC = $rtoi($floor(MR_DELAY_US * CLK_MHZ));
  localparam int          MR_CNT_W     = 12;
  localparam logic [MR_CNT_W-1:0] MR_TOTAL_CYC = MR_CNT_W'(MR_QUAL_CYC + MR_DELAY_CYC);

  // Watchdog timeout options, selected at build time.
  localparam real         WD_T_6P2_MS  = 6.2;
  localparam real         WD_T_102_MS  = 102.0;
  localparam real         WD_T_1600_MS = 1600.0;
  localparam int unsigned WD_CYC_6P2   = $rtoi($floor(WD_T_6P2_MS * 1000.0 * CLK_MHZ));
  localparam int unsigned WD_CYC_102   = $rtoi($floor(WD_T_102_MS * 1000.0 * CLK_MHZ));
  localparam int unsigned WD_CYC_1600  = $rtoi($floor(WD_T_1600_MS * 1000.0 * CLK_MHZ));

  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Sensed inputs, carried together through the synchroniser
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic supply_low;
    logic low_line;
    logic pf_below;
    logic manual_reset_n;
    logic watchdog_kick;
  } srw_sense_t;

  localparam int SENSE_W = $bits(srw_sense_t);
  // Manual reset idles high, as if pulled up; everything else idles low.
  localparam logic [SENSE_W-1:0] SENSE_RST = 5'h02;

  // ---------------------------------------------------------------------------
  // Reset sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_RUN  = 2'b01
  } srw_seq_t;

endpackage

/* src/srw_sync.sv */
// Two-stage synchroniser bank for the asynchronous sensing inputs.
module srw_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock, reset and enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ---------------------------------------------------------------------------
  // One pair of flip-flops per bit
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_ff[i] <= RST_VAL[i];
        sync_ff[i] <= RST_VAL[i];
      end else if (ce) begin
        meta_ff[i] <= d_in[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign q_out = sync_ff;

endmodule

/* src/srw_top.sv */
// Supervisor core: reset sequencer, manual reset, watchdog and warning outputs.
module srw_top #(
  parameter logic [31:0] RST_TIMEOUT_CYC = srw_pkg::RST_CYC_DEF,
  parameter logic [31:0] WD_TIMEOUT_CYC  = srw_pkg::WD_CYC_6P2,
  parameter bit          RST_ACTIVE_HIGH = 1'b0
) (
  // Oscillator clock, power-on reset and enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Comparator indications
  input  wire logic supply_low_in,
  input  wire logic low_line_in,
  input  wire logic power_fail_sense_in,
  // Processor-side pins
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick_in,
  // Outputs to the processor
  output logic      reset_out,
  output logic      power_fail_warn_n,
  output logic      low_line_warn_n
);

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  srw_pkg::srw_sense_t sense_raw;
  srw_pkg::srw_sense_t sense_s;
  logic [srw_pkg::SENSE_W-1:0] sense_q;

  always_comb begin
    sense_raw.supply_low     = supply_low_in;
    sense_raw.low_line       = low_line_in;
    sense_raw.pf_below       = power_fail_sense_in;
    sense_raw.manual_reset_n = manual_reset_n;
    sense_raw.watchdog_kick  = watchdog_kick_in;
  end

  srw_sync #(
    .W       (srw_pkg::SENSE_W),
    .RST_VAL (srw_pkg::SENSE_RST)
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .d_in  (sense_raw),
    .q_out (sense_q)
  );

  assign sense_s = srw_pkg::srw_sense_t'(sense_q);

  // ---------------------------------------------------------------------------
  // Manual reset qualifier
  // ---------------------------------------------------------------------------
  // The count covers the qualifying width and the assertion delay in one go,
  // so a low pulse that ends early never reaches the sequencer at all.
  logic [srw_pkg::MR_CNT_W-1:0] mr_cnt_ff;
  logic [srw_pkg::MR_CNT_W-1:0] nxt_mr_cnt;
  logic                         mr_act_ff;
  logic                         nxt_mr_act;

  always_comb begin
    nxt_mr_cnt = mr_cnt_ff;
    nxt_mr_act = mr_act_ff;
    if (sense_s.manual_reset_n) begin
      nxt_mr_cnt = '0;
      nxt_mr_act = 1'b0;
    end else if (!mr_act_ff) begin
      if (mr_cnt_ff == srw_pkg::MR_TOTAL_CYC - 12'h001) begin
        nxt_mr_act = 1'b1;
      end else begin
        nxt_mr_cnt = mr_cnt_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr_cnt_ff <= '0;
      mr_act_ff <= 1'b0;
    end else if (ce) begin
      mr_cnt_ff <= nxt_mr_cnt;
      mr_act_ff <= nxt_mr_act;
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  logic                     kick_prev_ff;
  logic                     kick_edge;
  logic [srw_pkg::CNT_W-1:0] wd_cnt_ff;
  logic [srw_pkg::CNT_W-1:0] nxt_wd_cnt;
  logic                     wd_trip;
  srw_pkg::srw_seq_t        seq_ff;

  assign kick_edge = sense_s.watchdog_kick ^ kick_prev_ff;

  always_comb begin
    nxt_wd_cnt = wd_cnt_ff + srw_pkg::CNT_ONE;
    wd_trip    = 1'b0;
    if (seq_ff == srw_pkg::SEQ_HOLD) begin
      nxt_wd_cnt = srw_pkg::CNT_ZERO;
    end else if (kick_edge) begin
      nxt_wd_cnt = srw_pkg::CNT_ZERO;
    end else if (wd_cnt_ff == WD_TIMEOUT_CYC - srw_pkg::CNT_ONE) begin
      nxt_wd_cnt = srw_pkg::CNT_ZERO;
      wd_trip    = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_prev_ff <= 1'b0;
      wd_cnt_ff    <= srw_pkg::CNT_ZERO;
    end else if (ce) begin
      kick_prev_ff <= sense_s.watchdog_kick;
      wd_cnt_ff    <= nxt_wd_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------------------
  // Any active cause pins the timer at zero; the timeout only runs once every
  // cause has gone, so a dip during the wait starts it over.
  logic                     rst_req;
  logic [srw_pkg::CNT_W-1:0] tmr_ff;
  logic [srw_pkg::CNT_W-1:0] nxt_tmr;
  srw_pkg::srw_seq_t        nxt_seq;

  assign rst_req = sense_s.supply_low | mr_act_ff | wd_trip;

  always_comb begin
    nxt_seq = seq_ff;
    nxt_tmr = tmr_ff;
    case (seq_ff)
      srw_pkg::SEQ_HOLD: begin
        if (rst_req) begin
          nxt_tmr = srw_pkg::CNT_ZERO;
        end else if (tmr_ff == RST_TIMEOUT_CYC - srw_pkg::CNT_ONE) begin
          nxt_tmr = srw_pkg::CNT_ZERO;
          nxt_seq = srw_pkg::SEQ_RUN;
        end else begin
          nxt_tmr = tmr_ff + srw_pkg::CNT_ONE;
        end
      end
      srw_pkg::SEQ_RUN: begin
        nxt_tmr = srw_pkg::CNT_ZERO;
        if (rst_req) begin
          nxt_seq = srw_pkg::SEQ_HOLD;
        end
      end
      default: begin
        nxt_tmr = srw_pkg::CNT_ZERO;
        nxt_seq = srw_pkg::SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_ff <= srw_pkg::SEQ_HOLD;
      tmr_ff <= srw_pkg::CNT_ZERO;
    end else if (ce) begin
      seq_ff <= nxt_seq;
      tmr_ff <= nxt_tmr;
    end
  end

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------
  // The warning comparators feed their pins directly and touch nothing else,
  // which keeps the power-fail comparator free for unrelated supplies.
  logic reset_out_ff;
  logic nxt_reset_out;
  logic pf_warn_n_ff;
  logic nxt_pf_warn_n;
  logic ll_warn_n_ff;
  logic nxt_ll_warn_n;

  always_comb begin
    nxt_reset_out = (nxt_seq == srw_pkg::SEQ_HOLD) ~^ RST_ACTIVE_HIGH;
    nxt_pf_warn_n = ~sense_s.pf_below;
    nxt_ll_warn_n = ~sense_s.low_line;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_out_ff <= RST_ACTIVE_HIGH;
      pf_warn_n_ff <= 1'b1;
      ll_warn_n_ff <= 1'b1;
    end else if (ce) begin
      reset_out_ff <= nxt_reset_out;
      pf_warn_n_ff <= nxt_pf_warn_n;
      ll_warn_n_ff <= nxt_ll_warn_n;
    end
  end

  assign reset_out         = reset_out_ff;
  assign power_fail_warn_n = pf_warn_n_ff;
  assign low_line_warn_n   = ll_warn_n_ff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SUPPLY_ASSERTS: assert property (
    ce && sense_s.supply_low |=> seq_ff == srw_pkg::SEQ_HOLD
  ) else $error("Supply low did not assert reset.");

  AST_TIMER_RESTART: assert property (
    ce && sense_s.supply_low |=> tmr_ff == srw_pkg::CNT_ZERO
  ) else $error("Reset timer not restarted by supply dip.");

  AST_RELEASE_AT_TIMEOUT: assert property (
    ce && seq_ff == srw_pkg::SEQ_HOLD && !rst_req
      && tmr_ff == RST_TIMEOUT_CYC - srw_pkg::CNT_ONE
    |=> seq_ff == srw_pkg::SEQ_RUN
  ) else $error("Reset not released after full timeout.");

  AST_NO_EARLY_RELEASE: assert property (
    seq_ff == srw_pkg::SEQ_RUN && $past(seq_ff) == srw_pkg::SEQ_HOLD
    |-> $past(tmr_ff) == RST_TIMEOUT_CYC - srw_pkg::CNT_ONE && !$past(rst_req)
  ) else $error("Reset released before timeout elapsed.");

  AST_POLARITY: assert property (
    reset_out == ((seq_ff == srw_pkg::SEQ_HOLD) ~^ RST_ACTIVE_HIGH)
  ) else $error("Reset output polarity does not match state.");

  AST_MR_QUALIFIES: assert property (
    ce && !sense_s.manual_reset_n && !mr_act_ff
      && mr_cnt_ff == srw_pkg::MR_TOTAL_CYC - 12'h001
    |=> mr_act_ff
  ) else $error("Qualified manual reset did not assert.");

  AST_MR_SHORT_IGNORED: assert property (
    ce && sense_s.manual_reset_n |=> mr_cnt_ff == '0 && !mr_act_ff
  ) else $error("Manual high did not clear the qualifier.");

  AST_MR_HOLDS: assert property (
    ce && mr_act_ff |=> seq_ff == srw_pkg::SEQ_HOLD && tmr_ff == srw_pkg::CNT_ZERO
  ) else $error("Reset not held while manual reset active.");

  AST_PF_FOLLOWS: assert property (
    ce |=> power_fail_warn_n == !$past(sense_s.pf_below)
  ) else $error("Power-fail output does not follow its input.");

  AST_LL_FOLLOWS: assert property (
    ce |=> low_line_warn_n == !$past(sense_s.low_line)
  ) else $error("Low-line output does not follow its input.");

  AST_WD_EDGE_CLEARS: assert property (
    ce && kick_edge |=> wd_cnt_ff == srw_pkg::CNT_ZERO
  ) else $error("Watchdog edge did not clear the counter.");

  AST_WD_TRIPS: assert property (
    ce && seq_ff == srw_pkg::SEQ_RUN && !kick_edge
      && wd_cnt_ff == WD_TIMEOUT_CYC - srw_pkg::CNT_ONE
    |=> seq_ff == srw_pkg::SEQ_HOLD
  ) else $error("Watchdog timeout did not assert reset.");

  AST_WD_CLEAR_IN_HOLD: assert property (
    ce && seq_ff == srw_pkg::SEQ_HOLD |=> wd_cnt_ff == srw_pkg::CNT_ZERO
  ) else $error("Watchdog counter ran during reset.");

  AST_WD_RESTART: assert property (
    seq_ff == srw_pkg::SEQ_RUN && $past(seq_ff) == srw_pkg::SEQ_HOLD
    |-> wd_cnt_ff == srw_pkg::CNT_ZERO
  ) else $error("Watchdog counter did not restart at release.");

  AST_WD_COUNTS: assert property (
    ce && seq_ff == srw_pkg::SEQ_RUN && !kick_edge
      && wd_cnt_ff != WD_TIMEOUT_CYC - srw_pkg::CNT_ONE
    |=> wd_cnt_ff == $past(wd_cnt_ff) + srw_pkg::CNT_ONE
  ) else $error("Watchdog counter did not advance.");

  AST_TMR_COUNTS: assert property (
    ce && seq_ff == srw_pkg::SEQ_HOLD && !rst_req
      && tmr_ff != RST_TIMEOUT_CYC - srw_pkg::CNT_ONE
    |=> seq_ff == srw_pkg::SEQ_HOLD && tmr_ff == $past(tmr_ff) + srw_pkg::CNT_ONE
  ) else $error("Reset timer did not advance while causes were clear.");

  // Checked at the first edge after reset lets go, where the cleared state shows.
  AST_POR_CLEAR: assert property (
    $past(rst) |-> seq_ff == srw_pkg::SEQ_HOLD && tmr_ff == srw_pkg::CNT_ZERO
      && wd_cnt_ff == srw_pkg::CNT_ZERO && mr_cnt_ff == '0
  ) else $error("State not cleared by power-on reset.");

endmodule

/* dv/srw_cpu_model.sv */
// Processor model that takes the reset line and toggles the watchdog pin.
module srw_cpu_model #(
  parameter int PERIOD      = 32'h0000_0014,
  parameter bit ACTIVE_HIGH = 1'b0
) (
  // Clock and control from the bench
  input  wire logic clk,
  input  wire logic kick_en,
  // Supervisor pins
  input  wire logic reset_out,
  output logic      watchdog_kick_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    watchdog_kick_in = 1'b0;
    cnt = 0;
  end
  // Code only runs while reset is released, so no kicks arrive during reset.
  always @(negedge clk) begin
    if (reset_out === ACTIVE_HIGH || !kick_en) begin
      cnt = 0;
    end else if (cnt == PERIOD - 1) begin
      cnt = 0;
      watchdog_kick_in = ~watchdog_kick_in;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule

/* dv/srw_top_bench.sv */
// Self-checking bench for the supervisor reset and watchdog core.
module srw_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Settings and signals
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_N = 32'h0000_0014;
  localparam logic [31:0] WD_N  = 32'h0000_0032;
  localparam logic [31:0] MR_N  = 32'h0000_0e74;
  localparam logic [31:0] KICK  = 32'h0000_0014;
  // Latency of synchroniser and sequencer is a few cycles, so counts get slack.
  localparam logic [31:0] SLK   = 32'h0000_0006;
  localparam logic        ON    = 1'b0;
  logic clk;
  logic rst;
  logic ce;
  logic supply_low_in;
  logic low_line_in;
  logic power_fail_sense_in;
  logic manual_reset_n;
  logic kick_en;
  logic watchdog_kick_in;
  logic reset_out;
  logic power_fail_warn_n;
  logic low_line_warn_n;
  logic reset_out_ah;
  int   fails;
  int   cmp_count;
  int   n;
  logic ok;

  srw_top #(.RST_TIMEOUT_CYC(RST_N), .WD_TIMEOUT_CYC(WD_N), .RST_ACTIVE_HIGH(1'b0)) u_dut (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .supply_low_in      (supply_low_in),
    .low_line_in        (low_line_in),
    .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_n     (manual_reset_n),
    .watchdog_kick_in   (watchdog_kick_in),
    .reset_out          (reset_out),
    .power_fail_warn_n  (power_fail_warn_n),
    .low_line_warn_n    (low_line_warn_n)
  );
  // Active-high build fed the same pins; its reset must mirror the main one.
  srw_top #(.RST_TIMEOUT_CYC(RST_N), .WD_TIMEOUT_CYC(WD_N), .RST_ACTIVE_HIGH(1'b1)) u_dut_ah (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .supply_low_in      (supply_low_in),
    .low_line_in        (low_line_in),
    .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_n     (manual_reset_n),
    .watchdog_kick_in   (watchdog_kick_in),
    .reset_out          (reset_out_ah),
    .power_fail_warn_n  (),
    .low_line_warn_n    ()
  );
  srw_cpu_model #(.PERIOD(KICK), .ACTIVE_HIGH(1'b0)) u_cpu (
    .clk             (clk),
    .kick_en         (kick_en),
    .reset_out       (reset_out),
    .watchdog_kick_in(watchdog_kick_in)
  );

  always #5 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_rst(input logic lvl, input int lim, output int cyc);
    cyc = 0;
    while (reset_out !== lvl && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  task automatic stays(input logic lvl, input int len, output logic good);
    good = 1'b1;
    repeat (len) begin
      @(negedge clk);
      if (reset_out !== lvl) good = 1'b0;
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_power_on();
    check("reset during por", reset_out, ON);
    check("active-high during por", reset_out_ah, 1'b1);
    check("pf warn during por", power_fail_warn_n, 1'b1);
    rst = 1'b0;
    wait_rst(~ON, RST_N + SLK + 4, n);
    check("por release window", n >= RST_N && n <= RST_N + SLK, 1'b1);
    check("active-high released", reset_out_ah, 1'b0);
  endtask

  task automatic t_brownout();
    supply_low_in = 1'b1;
    wait_rst(ON, 8, n);
    check("brownout assert delay", n <= 4 && reset_out === ON, 1'b1);
    repeat (5) @(negedge clk);
    supply_low_in = 1'b0;
    stays(ON, 10, ok);
    check("dip holds reset", ok, 1'b1);
    supply_low_in = 1'b1;
    repeat (2) @(negedge clk);
    supply_low_in = 1'b0;
    wait_rst(~ON, RST_N + SLK + 4, n);
    check("dip restarts wait", n >= RST_N && n <= RST_N + SLK, 1'b1);
  endtask

  task automatic t_manual();
    manual_reset_n = 1'b0;
    stays(~ON, MR_N - 200, ok);
    check("short manual ignored", ok, 1'b1);
    manual_reset_n = 1'b1;
    repeat (5) @(negedge clk);
    manual_reset_n = 1'b0;
    wait_rst(ON, MR_N + SLK + 4, n);
    check("manual assert delay", n >= MR_N && n <= MR_N + SLK, 1'b1);
    stays(ON, 100, ok);
    check("held while manual low", ok, 1'b1);
    manual_reset_n = 1'b1;
    wait_rst(~ON, RST_N + SLK + 4, n);
    check("manual release wait", n >= RST_N && n <= RST_N + SLK, 1'b1);
  endtask

  task automatic t_watchdog();
    stays(~ON, 10 * WD_N, ok);
    check("kicks keep reset off", ok, 1'b1);
    kick_en = 1'b0;
    wait_rst(ON, WD_N + SLK + 4, n);
    check("watchdog trip", n >= WD_N - KICK && n <= WD_N + SLK, 1'b1);
    wait_rst(~ON, RST_N + SLK + 4, n);
    check("watchdog reset length", n >= RST_N && n <= RST_N + 3, 1'b1);
    wait_rst(ON, WD_N + SLK + 4, n);
    check("counter restarts at release", n >= WD_N - 1 && n <= WD_N + 4, 1'b1);
    kick_en = 1'b1;
    wait_rst(~ON, RST_N + SLK + 4, n);
    check("second release", reset_out, !ON);
  endtask

  task automatic t_warn();
    power_fail_sense_in = 1'b1;
    repeat (4) @(negedge clk);
    check("pf warn low", power_fail_warn_n, 1'b0);
    stays(~ON, 60, ok);
    check("pf leaves reset alone", ok, 1'b1);
    power_fail_sense_in = 1'b0;
    low_line_in = 1'b1;
    repeat (4) @(negedge clk);
    check("pf warn high", power_fail_warn_n, 1'b1);
    check("low line warn low", low_line_warn_n, 1'b0);
    low_line_in = 1'b0;
    repeat (4) @(negedge clk);
    check("low line warn high", low_line_warn_n, 1'b1);
  endtask

  task automatic t_freeze();
    ce = 1'b0;
    supply_low_in = 1'b1;
    stays(!ON, 10, ok);
    check("enable low freezes state", ok, 1'b1);
    ce = 1'b1;
    wait_rst(ON, 8, n);
    check("assert after enable", n <= 4 && reset_out === ON, 1'b1);
    supply_low_in = 1'b0;
    wait_rst(!ON, RST_N + SLK + 4, n);
    check("release after enable", n >= RST_N && n <= RST_N + SLK, 1'b1);
  endtask

  task automatic t_mid_reset();
    rst = 1'b1;
    #1;
    check("async reset asserts", reset_out, ON);
    check("active-high mid reset", reset_out_ah, 1'b1);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    wait_rst(!ON, RST_N + SLK + 4, n);
    check("release after mid reset", n >= RST_N && n <= RST_N + SLK, 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    supply_low_in = 1'b0;
    low_line_in = 1'b0;
    power_fail_sense_in = 1'b0;
    manual_reset_n = 1'b1;
    kick_en = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    t_power_on();
    t_brownout();
    t_warn();
    t_freeze();
    t_watchdog();
    t_mid_reset();
    t_manual();
    results();
  end

  // The whole run needs well under 12000 cycles.
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule
